// File: tm8_timer.sv
// 8-bit timer/counter with shared prescaler, top level
// How it works
// - source select clear: count every instruction cycle
// - count write blocks advancing two instruction cycles
// - source select set: count pin edges instead
// - edge select clear rising, set falling
// - prescaler on timer or watchdog, never both
// - assign bit plus ratio field set prescale
// - prescaler count has no software access
// - count write clears prescaler when on timer
// - watchdog clear clears prescaler when on watchdog
// - reset forces prescaler to zero
// - without prescaler, pin feeds synchroniser directly
// - prescaler output sampled on phases two, four
// - count advances after registered synchronised edge
// - source select overrides count pin direction
// - eight-bit read/write count at address 01h
`timescale 1ns/1ps
module tm8_timer (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire tm8_pkg::tm8_wr_t reg_wr,
	input wire logic reg_rd,
	input wire logic opt_wr,
	input wire logic [7:0] opt_wdata,
	input wire logic dir_wr,
	input wire logic [3:0] dir_wdata,
	input wire logic watchdog_clear_op,
	input wire logic wdt_tick_in,
	input wire logic ext_count_in,
	output logic [7:0] rd_data_ff,
	output logic [7:0] timer_count_ff,
	output logic [3:0] pin_direction_ff,
	output logic wdt_post_tick_ff,
	output logic [1:0] phase_ff
);

	// ==========================================
	// declarations
	tm8_pkg::tm8_opt_t opt_ff; // write-only config
	logic [3:0] dir_ff; // write-only direction latch
	logic [3:0] inhib_ff; // cycles left with advance blocked
	logic pin_sync; // count pin after two flops
	logic src_lvl; // level whose rising edge clocks the path
	logic src_d_ff; // previous source level
	logic src_rise; // one-cycle source edge
	logic pre_on_tmr; // prescaler sits on the timer
	logic pre_clr; // clear request for the prescaler
	logic pre_inc; // prescaler advance
	logic pre_tap; // selected prescaler bit
	logic [7:0] pre_cnt; // prescaler value, internal only
	logic pre_out; // prescaler output or bypass
	logic tap_d_ff; // previous tap for watchdog edges
	logic samp_ff; // output sampled on q2 and q4
	logic samp_d_ff; // registered sample
	logic inc_pulse; // timer advance this cycle
	logic tmr_wr_hit; // write to the count register
	logic q_sample; // q2 or q4 of the cycle
	logic [3:0] nxt_dir; // direction with override

	// ==========================================
	// pin synchroniser
	// the pin may change at any time, so it passes two flops
	tm8_sync2 u_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.async_in(ext_count_in),
		.sync_out(pin_sync)
	);

	// ==========================================
	// instruction cycle phase
	// four core clocks form one instruction cycle
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			phase_ff <= 2'h0;
		end else begin
			phase_ff <= phase_ff + 2'h1;
		end
	end

	// sampling points of the synchroniser
	assign q_sample = (phase_ff == tm8_pkg::PH_Q2) || (phase_ff == tm8_pkg::PH_Q4);

	// ==========================================
	// configuration
	// config loaded whole, software cannot read it back
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			opt_ff <= tm8_pkg::OPT_RST;
		end else if (opt_wr) begin
			opt_ff <= opt_wdata;
		end
	end

	// direction latch for the port pins
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			dir_ff <= tm8_pkg::DIR_RST;
		end else if (dir_wr) begin
			dir_ff <= dir_wdata;
		end
	end

	// count pin forced to input while it is the count source
	always_comb begin
		nxt_dir = dir_ff;
		if (opt_ff.clock_source_sel) begin
			nxt_dir[tm8_pkg::CNT_PIN_BIT] = 1'b1;
		end
	end

	// direction output straight from a flop
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pin_direction_ff <= tm8_pkg::DIR_RST;
		end else begin
			pin_direction_ff <= nxt_dir;
		end
	end

	// ==========================================
	// count source selection
	// timer mode uses phase msb: one rising edge per instruction
	// counter mode inverts the pin for falling edges
	always_comb begin
		if (opt_ff.clock_source_sel) begin
			src_lvl = pin_sync ^ opt_ff.count_edge_sel;
		end else begin
			src_lvl = phase_ff[1];
		end
	end

	// previous source level for edge finding
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			src_d_ff <= 1'b0;
		end else begin
			src_d_ff <= src_lvl;
		end
	end

	assign src_rise = src_lvl & ~src_d_ff;

	// ==========================================
	// prescaler routing
	assign pre_on_tmr = ~opt_ff.prescaler_assign;
	assign tmr_wr_hit = reg_wr.wr && (reg_wr.addr == tm8_pkg::TMR_ADDR);

	// a count write or a watchdog clear empties it, by owner
	always_comb begin
		if (pre_on_tmr) begin
			pre_clr = tmr_wr_hit;
		end else begin
			pre_clr = watchdog_clear_op;
		end
	end

	// the owner decides what the prescaler counts
	always_comb begin
		if (pre_on_tmr) begin
			pre_inc = src_rise;
		end else begin
			pre_inc = wdt_tick_in;
		end
	end

	// only clear and advance reach it; no load, no readback
	tm8_prescaler u_pre (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clr(pre_clr),
		.inc(pre_inc),
		.ratio(opt_ff.prescale_ratio),
		.cnt_ff(pre_cnt),
		.tap(pre_tap)
	);

	// without the prescaler the source bypasses it
	always_comb begin
		if (pre_on_tmr) begin
			pre_out = pre_tap;
		end else begin
			pre_out = src_lvl;
		end
	end

	// ==========================================
	// watchdog postscaler output
	// previous tap, to find its rising edge
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			tap_d_ff <= 1'b0;
		end else begin
			tap_d_ff <= pre_tap;
		end
	end

	// divided tick on watchdog, raw tick otherwise
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			wdt_post_tick_ff <= 1'b0;
		end else if (pre_on_tmr) begin
			wdt_post_tick_ff <= wdt_tick_in;
		end else begin
			wdt_post_tick_ff <= pre_tap & ~tap_d_ff;
		end
	end

	// ==========================================
	// phase sampling
	// held between samples, so a pin pulse must span a sample
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			samp_ff <= 1'b0;
		end else if (q_sample) begin
			samp_ff <= pre_out;
		end
	end

	// registered sample: adds the edge-to-advance delay
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			samp_d_ff <= 1'b0;
		end else begin
			samp_d_ff <= samp_ff;
		end
	end

	// advance on a sampled edge, unless a write holds it off
	assign inc_pulse = samp_ff & ~samp_d_ff & (inhib_ff == 4'h0);

	// ==========================================
	// write inhibit
	// the count loses edges during hold-off; software compensates
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			inhib_ff <= 4'h0;
		end else if (tmr_wr_hit) begin
			inhib_ff <= tm8_pkg::INHIBIT_CYC;
		end else if (inhib_ff != 4'h0) begin
			inhib_ff <= inhib_ff - 4'h1;
		end
	end

	// ==========================================
	// count register
	// write wins over an advance in the same cycle
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			timer_count_ff <= tm8_pkg::CNT_RST;
		end else if (tmr_wr_hit) begin
			timer_count_ff <= reg_wr.wdata;
		end else if (inc_pulse) begin
			timer_count_ff <= timer_count_ff + 8'h01;
		end
	end

	// ==========================================
	// read port
	// other addresses belong to other blocks and read zero here
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rd_data_ff <= 8'h00;
		end else if (reg_rd && (reg_wr.addr == tm8_pkg::TMR_ADDR)) begin
			rd_data_ff <= timer_count_ff;
		end else begin
			rd_data_ff <= 8'h00;
		end
	end

	// ==========================================
	// checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	sequence samp_edge_s;
		!samp_d_ff && samp_ff && (inhib_ff == 4'h0);
	endsequence

	sequence count_step_s;
		timer_count_ff == $past(timer_count_ff) + 8'h01;
	endsequence

	// timer mode without prescaler; a config load near the edge would retime it
	sequence rate_start_s;
		!opt_ff.clock_source_sel && opt_ff.prescaler_assign && $rose(samp_ff)
			&& !opt_wr && !$past(opt_wr) && !$past(opt_wr, 2);
	endsequence

	// a count write lands next cycle and arms the hold-off
	wr_load_a: assert property (tmr_wr_hit |=>
		(timer_count_ff == $past(reg_wr.wdata)) && (inhib_ff == 4'h8))
		else $error("count write not taken");

	// no advance while the hold-off runs
	wr_hold_a: assert property ((inhib_ff != 4'h0) && !tmr_wr_hit
		|=> $stable(timer_count_ff)) else $error("count moved during hold-off");

	// a count write empties a timer-owned prescaler
	wr_clr_pre_a: assert property (tmr_wr_hit && !opt_ff.prescaler_assign
		|=> pre_cnt == 8'h00) else $error("write left prescaler set");

	// a watchdog clear empties a watchdog-owned prescaler
	wdt_clr_pre_a: assert property (watchdog_clear_op && opt_ff.prescaler_assign
		|=> pre_cnt == 8'h00) else $error("watchdog clear left prescaler");

	// counter mode forces the count pin to input
	pin_dir_a: assert property (opt_ff.clock_source_sel
		|=> pin_direction_ff[2]) else $error("count pin not input");

	// the sample only moves on the two sampling phases
	samp_phase_a: assert property (!q_sample
		|=> $stable(samp_ff)) else $error("sample outside q2 q4");

	// every sampled edge outside hold-off adds exactly one
	edge_step_a: assert property ((samp_edge_s and !tmr_wr_hit)
		|=> count_step_s) else $error("sampled edge not counted");

	// nothing but a sampled edge or a write may move the count
	no_stray_a: assert property (!(!samp_d_ff && samp_ff && (inhib_ff == 4'h0)) && !tmr_wr_hit
		|=> $stable(timer_count_ff)) else $error("count moved without edge");

	// a watchdog-owned prescaler ignores the timer source
	wdt_route_a: assert property (opt_ff.prescaler_assign && !watchdog_clear_op
		&& !wdt_tick_in |=> $stable(pre_cnt)) else $error("timer drove watchdog prescaler");

	// one sampled rise per instruction cycle in plain timer mode
	timer_rate_a: assert property (rate_start_s ##1 (!opt_wr)[*3]
		|=> $rose(samp_ff)) else $error("timer mode not once per cycle");

	// a read of the count returns the value of the read cycle
	rd_count_a: assert property (reg_rd && (reg_wr.addr == tm8_pkg::TMR_ADDR)
		|=> rd_data_ff == $past(timer_count_ff)) else $error("count read wrong");

	// no read, or a read elsewhere, leaves the read data at zero
	rd_idle_a: assert property (!(reg_rd && (reg_wr.addr == tm8_pkg::TMR_ADDR))
		|=> rd_data_ff == 8'h00) else $error("read data not zero");

	// prescaler on the timer: watchdog tick passes one cycle late
	post_pass_a: assert property (!opt_ff.prescaler_assign
		|=> wdt_post_tick_ff == $past(wdt_tick_in)) else $error("watchdog tick not passed");

	// timer mode leaves the written directions alone
	dir_free_a: assert property (!opt_ff.clock_source_sel
		|=> pin_direction_ff == $past(dir_ff)) else $error("direction not followed");

endmodule

// File: tm8_pkg.sv
// constants and types shared by the 8-bit timer and its prescaler
package tm8_pkg;

	// ==========================================
	// register locations and widths
	localparam logic [4:0] TMR_ADDR = 5'h01; // data address of the count
	localparam int CNT_W = 8; // width of the count and prescaler
	localparam int DIR_W = 4; // width of the pin direction register
	localparam int CNT_PIN_BIT = 2; // direction bit of the count input pin

	// ==========================================
	// reset values
	localparam logic [7:0] OPT_RST = 8'hff; // all config bits set
	localparam logic [3:0] DIR_RST = 4'hf; // all pins input
	localparam logic [7:0] CNT_RST = 8'h00; // defined start for the count
	localparam logic [7:0] PRE_RST = 8'h00; // prescaler cleared on reset

	// ==========================================
	// instruction cycle timing
	localparam int CLK_HZ = 40_000_000; // core_clk rate
	localparam int QPHASES = 4; // internal phases per instruction cycle
	localparam int INHIBIT_INSTR = 2; // instruction cycles held after a write
	localparam logic [3:0] INHIBIT_CYC = 4'(INHIBIT_INSTR * QPHASES);
	localparam logic [1:0] PH_Q2 = 2'h1; // second phase index
	localparam logic [1:0] PH_Q4 = 2'h3; // fourth phase index

	// ==========================================
	// config register layout, msb first
	typedef struct packed {
		logic wake_en; // not used by this block
		logic pullup_en; // not used by this block
		logic clock_source_sel; // 1: count pin edges
		logic count_edge_sel; // 1: falling edge
		logic prescaler_assign; // 1: prescaler on watchdog
		logic [2:0] prescale_ratio; // divide by 2^(ratio+1)
	} tm8_opt_t;

	// register write port from the core
	typedef struct packed {
		logic wr; // one-cycle write strobe
		logic [4:0] addr; // data address
		logic [7:0] wdata; // write data
	} tm8_wr_t;

endpackage

// File: tm8_sync2.sv
// two-stage synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
module tm8_sync2 (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic async_in,
	output logic sync_out
);

	// ==========================================
	// chain
	logic meta_ff; // first stage, read only by the second

	// first stage samples the raw pin
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			meta_ff <= 1'b0;
		end else begin
			meta_ff <= async_in;
		end
	end

	// second stage feeds the rest of the block
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sync_out <= 1'b0;
		end else begin
			sync_out <= meta_ff;
		end
	end

endmodule

// File: tm8_prescaler.sv
// shared 8-bit prescaler with a selectable output tap
`timescale 1ns/1ps
module tm8_prescaler (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clr,
	input wire logic inc,
	input wire logic [2:0] ratio,
	output logic [7:0] cnt_ff,
	output logic tap
);

	// ==========================================
	// counter, no software path to it at all
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cnt_ff <= tm8_pkg::PRE_RST;
		end else if (clr) begin
			cnt_ff <= tm8_pkg::PRE_RST;
		end else if (inc) begin
			cnt_ff <= cnt_ff + 8'h01;
		end
	end

	// tap n toggles once per 2^n input edges, so it rises once per 2^(n+1)
	assign tap = cnt_ff[ratio];

	// ==========================================
	// checks
	clr_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		clr |=> cnt_ff == 8'h00) else $error("prescaler not cleared");

endmodule

// File: tm8_ext_src.sv
// count pin source model: toggles the pin a set number of times
`timescale 1ns/1ps
module tm8_ext_src (
	input wire logic go,
	input wire logic [7:0] n_edges,
	input wire logic [15:0] half_ns,
	output logic pin,
	output logic busy
);
	// ==========================================
	// edge generator
	initial begin
		pin = 1'b0;
		busy = 1'b0;
	end
	// each level held half_ns, never under two core clocks
	// pin holds its last level between bursts, like a real source
	always @(posedge go) begin
		busy = 1'b1;
		repeat (n_edges) begin
			#(half_ns) pin = ~pin;
		end
		#(half_ns) busy = 1'b0;
	end
endmodule

// File: tm8_tb.sv
// self-checking bench for the 8-bit timer and its prescaler
`timescale 1ns/1ps
module tb;
	// ==========================================
	// stimulus and observed signals
	logic core_clk, rst_n, reg_rd, opt_wr, dir_wr, wd_clr, wd_tick, go, pin, busy, post;
	tm8_pkg::tm8_wr_t reg_wr;
	logic [7:0] opt_wdata, n_edges, rd_data, cnt, c0;
	logic [3:0] dir_wdata, dir;
	logic [15:0] half_ns;
	logic [1:0] phase, ph0;
	int miscompares, n_checks, n_post, np;

	tm8_timer u_dut (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.opt_wr(opt_wr),
		.opt_wdata(opt_wdata),
		.dir_wr(dir_wr),
		.dir_wdata(dir_wdata),
		.watchdog_clear_op(wd_clr),
		.wdt_tick_in(wd_tick),
		.ext_count_in(pin),
		.rd_data_ff(rd_data),
		.timer_count_ff(cnt),
		.pin_direction_ff(dir),
		.wdt_post_tick_ff(post),
		.phase_ff(phase)
	);
	tm8_ext_src u_src (.go(go), .n_edges(n_edges), .half_ns(half_ns), .pin(pin), .busy(busy));

	// ==========================================
	// clock, monitor, watchdog
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// count post-tick pulses, the only view of the watchdog side
	always @(posedge core_clk) begin
		if (post === 1'b1) begin
			n_post <= n_post + 1;
		end
	end
	// run needs about 11000 clocks
	initial begin
		repeat (40000) @(posedge core_clk);
		miscompares++;
		finish_test();
	end

	// ==========================================
	// tasks
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// n rising edges, then settle at the falling edge
	task automatic clk(input int n);
		repeat (n) @(posedge core_clk);
		@(negedge core_clk);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		clk(1);
		s = 1'b0;
	endtask
	task automatic cfg(input logic [7:0] v);
		opt_wdata = v;
		pulse(opt_wr);
	endtask
	task automatic wr_cnt(input logic [7:0] d);
		reg_wr = '{wr: 1'b1, addr: tm8_pkg::TMR_ADDR, wdata: d};
		clk(1);
		reg_wr.wr = 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		reg_wr.addr = a;
		pulse(reg_rd);
		check("rd_data", rd_data, e);
	endtask
	// ticks spaced two clocks apart so each is a clean pulse
	task automatic tick(input int n);
		repeat (n) begin
			pulse(wd_tick);
			clk(1);
		end
	endtask
	task automatic edges(input logic [7:0] n, input logic [15:0] h);
		n_edges = n;
		half_ns = h;
		pulse(go);
		for (int i = 0; i < 4000 && busy !== 1'b0; i++) clk(1);
		clk(12);
	endtask
	task automatic finish_test();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ==========================================
	// main sequence
	initial begin
		{rst_n, reg_rd, opt_wr, dir_wr, wd_clr, wd_tick, go} = '0;
		reg_wr = '0;
		{opt_wdata, n_edges, dir_wdata, half_ns} = '0;
		{miscompares, n_checks, n_post} = '0;
		clk(3);
		rst_n = 1'b1;
		check("count", cnt, tm8_pkg::CNT_RST);
		check("dir", 8'(dir), 8'(tm8_pkg::DIR_RST));
		for (int i = 0; i < 8; i++) begin
			ph0 = phase;
			clk(1);
			check("phase", 8'(phase), 8'(2'(ph0 + 2'h1)));
		end
		// timer mode, no prescaler: inhibit then wrap
		cfg(8'h08);
		wr_cnt(8'hfe);
		clk(8);
		check("inhibit", cnt, 8'hfe);
		clk(8);
		check("wrap", cnt, 8'h00);
		// every ratio: two periods give exactly two advances
		for (int r = 0; r < 8; r++) begin
			cfg(8'(r));
			clk(16 << r);
			c0 = cnt;
			clk(16 << r);
			check("ratio", cnt, c0 + 8'h02);
		end
		// write late in a prescale period must restart it
		c0 = cnt;
		for (int i = 0; i < 1100 && cnt === c0; i++) clk(1);
		clk(900);
		wr_cnt(8'h40);
		clk(300);
		check("pre clear", cnt, 8'h40);
		// prescaler on timer: watchdog tick passes straight through
		np = n_post;
		tick(1);
		clk(3);
		check("wdt pass", 8'(n_post - np), 8'h01);
		// move to watchdog with clears around the switch
		pulse(wd_clr);
		cfg(8'h09);
		pulse(wd_clr);
		// the tap swap at the config load may give one tick; let it pass
		clk(2);
		np = n_post;
		tick(2);
		clk(3);
		check("wdt div4", 8'(n_post - np), 8'h01);
		tick(1);
		pulse(wd_clr);
		np = n_post;
		tick(2);
		clk(3);
		check("wdt clear", 8'(n_post - np), 8'h01);
		// counter mode: direction override, reads, edges
		dir_wdata = 4'h0;
		pulse(dir_wr);
		clk(2);
		check("dir", 8'(dir), 8'h00);
		cfg(8'h28);
		clk(2);
		check("dir", 8'(dir), 8'h04);
		wr_cnt(8'ha5);
		clk(10);
		rd(tm8_pkg::TMR_ADDR, 8'ha5);
		rd(5'h02, 8'h00);
		edges(8'd5, 16'd100);
		check("rising", cnt, 8'ha8);
		cfg(8'h38);
		edges(8'd5, 16'd250);
		check("falling", cnt, 8'hab);
		cfg(8'h20);
		wr_cnt(8'h00);
		clk(10);
		edges(8'd8, 16'd100);
		check("pin div2", cnt, 8'h02);
		// second reset must empty the prescaler
		rst_n = 1'b0;
		clk(2);
		rst_n = 1'b1;
		check("count", cnt, tm8_pkg::CNT_RST);
		np = n_post;
		tick(127);
		clk(3);
		check("rst pre", 8'(n_post - np), 8'h00);
		tick(1);
		clk(3);
		check("rst pre", 8'(n_post - np), 8'h01);
		finish_test();
	end
endmodule
